// File: rtl/cws_pkg.sv
// Purpose: Constants and types for the configuration word start-up block
// Assumes: 14-bit configuration word, 100 MHz hclk, AHB-Lite registers
// Notes:   Behaviour list below; tags mark the logic in cws_top
//
// Behaviour
// [R1] Word lives at 2007h, programming access only
// [R2] Programmed bit reads zero, erased reads one
// [R3] Bits 15 to 13 always read one
// [R4] Debug bit one frees pins as GPIO
// [R5] Clock monitor on when bit is one
// [R6] Clock switchover on when bit is one
// [R7] Brown-out field: always, run-only, soft, off
// [R8] Data protect bit zero enables protection
// [R9] Program protect bit zero enables protection
// [R10] Reset pin select: external reset or input
// [R11] Power-up delay enable bit is active low
// [R12] Watchdog fuse or soft enable bit
// [R13] Oscillator field selects clock source mode
// [R14] Brown-out never enables power-up delay itself
// [R15] Data unprotect erases whole data memory
// [R16] Program unprotect erases whole program memory
// [R17] External reset in RC/internal stops oscillator
// [R18] Power-up delay holds reset, power-up only
// [R19] Crystal modes wait for start-up timer
// [R20] Brown-out reset reuses power-up delay
// [R21] Wake from sleep: reset, watchdog, interrupt
// [R22] Soft brown-out bit works in mode 01
// [R23] Power-up delay counts low-frequency oscillator
// [R24] Word sampled in reset, then held
package cws_pkg;

  localparam logic [13:0] CFG_ADDR     = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [13:0] CFG_ERASED   = 14'h3FFF;
  localparam logic [2:0]  CFG_UNIMPL   = 3'h7;

  typedef enum logic [2:0] {
    OSC_LP        = 3'h0,
    OSC_XT        = 3'h1,
    OSC_HS        = 3'h2,
    OSC_EC        = 3'h3,
    OSC_INT_IO    = 3'h4,
    OSC_INT_CLKO  = 3'h5,
    OSC_RC_IO     = 3'h6,
    OSC_RC_CLKO   = 3'h7
  } cws_osc_e;

  localparam logic [1:0] BOR_ALWAYS   = 2'h3;
  localparam logic [1:0] BOR_RUN_ONLY = 2'h2;
  localparam logic [1:0] BOR_SOFT     = 2'h1;
  localparam logic [1:0] BOR_OFF      = 2'h0;

  typedef struct packed {
    logic       debugger_off;
    logic       clock_monitor_enable;
    logic       int_ext_switchover_enable;
    logic [1:0] brownout_select;
    logic       data_protect_n;
    logic       program_protect_n;
    logic       reset_pin_select;
    logic       powerup_delay_enable_n;
    logic       watchdog_fuse_enable;
    cws_osc_e   osc_select;
  } cws_cfg_word_s;

  typedef struct packed {
    logic     debugger_enable;
    logic     prog_pins_gpio;
    logic     clock_monitor_enable;
    logic     int_ext_switchover_enable;
    logic     data_protect_en;
    logic     program_protect_en;
    logic     reset_pin_is_reset;
    logic     powerup_delay_en;
    cws_osc_e osc_select;
  } cws_opts_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_POWERUP_DELAY_TIMER = 2'b01,
    ST_OST  = 2'b11,
    ST_RUN  = 2'b10
  } cws_state_e;

  localparam int unsigned POWERUP_DELAY_TIMER_TIME_MS = 64;
  localparam int unsigned LFOSC_HZ     = 31000;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS   = POWERUP_DELAY_TIMER_TIME_MS * LFOSC_HZ / 1000;
  localparam int unsigned OST_CYCLES   = 1024;
  localparam int unsigned TCNT_W       = 11;

  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POWER_CONTROL_REG   = 8'h08;
  localparam logic [7:0] REG_WATCHDOG_CONTROL_REG = 8'h0C;

  localparam int unsigned ST_HOLD_BIT  = 0;
  localparam int unsigned ST_POWERUP_DELAY_TIMER_BIT  = 1;
  localparam int unsigned ST_OST_BIT   = 2;
  localparam int unsigned ST_BROWNOUT_SELECT_BIT = 3;
  localparam int unsigned ST_WDTEN_BIT = 4;
  localparam int unsigned ST_SLEEP_BIT = 5;
  localparam int unsigned ST_FSM_LSB   = 6;
  localparam int unsigned SOFT_EN_BIT  = 0;

  localparam logic SOFT_BOR_RST = 1'b0;
  localparam logic SOFT_WDT_RST = 1'b0;

endpackage

// File: rtl/cws_top.sv
// Purpose: Configuration word store, option decode and start-up sequencing
// Assumes: Tick inputs are one-cycle pulses synchronous to hclk
// Notes:   AHB-Lite slave with zero wait states, always OKAY
`timescale 1ns/1ps
module cws_top (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 prog_mode,
  input  wire logic                 prog_wr,
  input  wire logic [13:0]          prog_addr,
  input  wire logic [13:0]          prog_wdata,
  output logic      [15:0]          prog_rdata,
  input  wire logic                 lf_osc_tick,
  input  wire logic                 osc_clk_tick,
  input  wire logic                 brownout_detect,
  input  wire logic                 external_reset_n,
  input  wire logic                 sleep_req,
  input  wire logic                 wdt_wakeup,
  input  wire logic                 irq_pending,
  output cws_pkg::cws_opts_s        options,
  output logic                      brownout_enable,
  output logic                      watchdog_enable,
  output logic                      reset_pin_input,
  output logic                      int_osc_disable,
  output logic                      device_reset,
  output logic                      sleeping,
  output logic                      erase_data,
  output logic                      erase_program
);
  import cws_pkg::*;

  cws_cfg_word_s           nvm_ff;
  cws_cfg_word_s           cfg_ff;
  cws_cfg_word_s           nxt_nvm;
  cws_state_e              state_ff;
  cws_state_e              nxt_state;
  logic [TCNT_W-1:0]       cnt_ff;
  logic                    sleeping_ff;
  logic                    soft_bor_ff;
  logic                    soft_wdt_ff;
  logic                    erase_data_ff;
  logic                    erase_prog_ff;
  logic [15:0]             prog_rdata_ff;
  logic [31:0]             hrdata_ff;
  logic                    wr_pend_ff;
  logic [7:0]              wr_addr_ff;
  logic                    cfg_wr;
  logic                    ext_reset_active;
  logic                    bor_active;
  logic                    is_crystal;
  logic                    is_rc_int;
  logic                    powerup_delay_timer_done;
  logic                    ost_done;
  logic                    wake;
  logic                    ahb_go;
  logic [31:0]             rd_val;

  // Programming port: only the configuration word at CFG_ADDR answers
  assign cfg_wr  = prog_mode & prog_wr & (prog_addr == CFG_ADDR); // [R1]
  assign nxt_nvm = cfg_wr ? cws_cfg_word_s'(prog_wdata[12:0]) : nvm_ff;

  // Erased state is all ones; nvm content survives every reset but hresetn here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_ff <= cws_cfg_word_s'(CFG_ERASED[12:0]); // [R2]
    end else begin
      nvm_ff <= nxt_nvm;
    end
  end

  // Lifting protection wipes the protected array
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      erase_data_ff <= 1'b0;
      erase_prog_ff <= 1'b0;
    end else begin
      erase_data_ff <= cfg_wr & ~nvm_ff.data_protect_n
                       & nxt_nvm.data_protect_n; // [R15]
      erase_prog_ff <= cfg_wr & ~nvm_ff.program_protect_n
                       & nxt_nvm.program_protect_n; // [R16]
    end
  end

  // Readback outside programming mode is blanked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_rdata_ff <= 16'h0000;
    end else if (prog_mode && prog_addr == CFG_ADDR) begin
      prog_rdata_ff <= {CFG_UNIMPL, nvm_ff}; // [R1] [R3]
    end else begin
      prog_rdata_ff <= 16'h0000;
    end
  end

  // Sampled only in the load state, so options never move while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= cws_cfg_word_s'(CFG_ERASED[12:0]);
    end else if (state_ff == ST_LOAD) begin
      cfg_ff <= nvm_ff; // [R24]
    end
  end

  assign is_crystal = (cfg_ff.osc_select == OSC_LP)
                    | (cfg_ff.osc_select == OSC_XT)
                    | (cfg_ff.osc_select == OSC_HS);
  assign is_rc_int  = (cfg_ff.osc_select == OSC_INT_IO)
                    | (cfg_ff.osc_select == OSC_INT_CLKO)
                    | (cfg_ff.osc_select == OSC_RC_IO)
                    | (cfg_ff.osc_select == OSC_RC_CLKO); // [R13]

  always_comb begin
    options.debugger_enable           = ~cfg_ff.debugger_off; // [R4]
    options.prog_pins_gpio            = cfg_ff.debugger_off; // [R4]
    options.clock_monitor_enable      = cfg_ff.clock_monitor_enable; // [R5]
    options.int_ext_switchover_enable =
      cfg_ff.int_ext_switchover_enable; // [R6]
    options.data_protect_en           = ~cfg_ff.data_protect_n; // [R8]
    options.program_protect_en        = ~cfg_ff.program_protect_n; // [R9]
    options.reset_pin_is_reset        = cfg_ff.reset_pin_select; // [R10]
    options.powerup_delay_en          =
      ~cfg_ff.powerup_delay_enable_n; // [R11] [R14]
    options.osc_select                = cfg_ff.osc_select; // [R13]
  end

  // Internal tie-off keeps the reset inactive when the pin is an input
  assign ext_reset_active = cfg_ff.reset_pin_select & ~external_reset_n;
  assign reset_pin_input  = cfg_ff.reset_pin_select ? 1'b1
                                                    : external_reset_n; // [R10]
  assign int_osc_disable  = ext_reset_active & is_rc_int; // [R17]

  always_comb begin
    unique case (cfg_ff.brownout_select)
      BOR_ALWAYS:   brownout_enable = 1'b1; // [R7]
      BOR_RUN_ONLY: brownout_enable = ~sleeping_ff; // [R7]
      BOR_SOFT:     brownout_enable = soft_bor_ff; // [R7] [R22]
      BOR_OFF:      brownout_enable = 1'b0; // [R7]
    endcase
  end
  assign bor_active      = brownout_enable & brownout_detect;
  assign watchdog_enable = cfg_ff.watchdog_fuse_enable | soft_wdt_ff; // [R12]

  assign powerup_delay_timer_done = lf_osc_tick
                   && (cnt_ff == TCNT_W'(POWERUP_DELAY_TIMER_TICKS - 1)); // [R23]
  assign ost_done  = osc_clk_tick && (cnt_ff == TCNT_W'(OST_CYCLES - 1));

  // Start-up sequence: load, power-up delay, oscillator start-up, run
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LOAD: begin
        if (bor_active) begin
          nxt_state = ST_LOAD;
        end else if (!nvm_ff.powerup_delay_enable_n) begin
          nxt_state = ST_POWERUP_DELAY_TIMER; // [R18] [R20]
        end else if (nvm_ff.osc_select == OSC_LP
                     || nvm_ff.osc_select == OSC_XT
                     || nvm_ff.osc_select == OSC_HS) begin
          nxt_state = ST_OST; // [R19]
        end else begin
          nxt_state = ST_RUN;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (bor_active) begin
          nxt_state = ST_LOAD; // [R20]
        end else if (powerup_delay_timer_done) begin
          nxt_state = is_crystal ? ST_OST : ST_RUN; // [R19]
        end
      end
      ST_OST: begin
        if (bor_active) begin
          nxt_state = ST_LOAD;
        end else if (ost_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (bor_active) begin
          nxt_state = ST_LOAD; // [R20]
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // One counter serves both timers; cleared on every state change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (state_ff == ST_POWERUP_DELAY_TIMER && lf_osc_tick) begin
      cnt_ff <= cnt_ff + TCNT_W'(1); // [R23]
    end else if (state_ff == ST_OST && osc_clk_tick) begin
      cnt_ff <= cnt_ff + TCNT_W'(1); // [R19]
    end
  end

  // The external pin holds reset but does not restart the timers
  assign device_reset = (state_ff != ST_RUN) | ext_reset_active;

  assign wake = ext_reset_active | wdt_wakeup | irq_pending;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleeping_ff <= 1'b0;
    end else if (state_ff != ST_RUN || wake) begin
      sleeping_ff <= 1'b0; // [R21]
    end else if (sleep_req) begin
      sleeping_ff <= 1'b1;
    end
  end

  // AHB-Lite slave, zero wait states
  assign ahb_go = hsel & htrans[1] & hready;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      REG_CFG:    rd_val = {16'h0000, CFG_UNIMPL, cfg_ff}; // [R3]
      REG_STATUS: begin
        rd_val[ST_HOLD_BIT]  = device_reset;
        rd_val[ST_POWERUP_DELAY_TIMER_BIT]  = (state_ff == ST_POWERUP_DELAY_TIMER);
        rd_val[ST_OST_BIT]   = (state_ff == ST_OST);
        rd_val[ST_BROWNOUT_SELECT_BIT] = brownout_enable;
        rd_val[ST_WDTEN_BIT] = watchdog_enable;
        rd_val[ST_SLEEP_BIT] = sleeping_ff;
        rd_val[ST_FSM_LSB +: 2] = state_ff;
      end
      REG_POWER_CONTROL_REG:   rd_val[SOFT_EN_BIT] = soft_bor_ff;
      REG_WATCHDOG_CONTROL_REG: rd_val[SOFT_EN_BIT] = soft_wdt_ff;
      default:    rd_val = 32'h0000_0000;
    endcase
    if (|haddr[31:8]) begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= ahb_go & hwrite & ~(|haddr[31:8]);
      wr_addr_ff <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata_ff <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_bor_ff <= SOFT_BOR_RST;
      soft_wdt_ff <= SOFT_WDT_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == REG_POWER_CONTROL_REG) begin
        soft_bor_ff <= hwdata[SOFT_EN_BIT]; // [R22]
      end
      if (wr_addr_ff == REG_WATCHDOG_CONTROL_REG) begin
        soft_wdt_ff <= hwdata[SOFT_EN_BIT]; // [R12]
      end
    end
  end

  assign hrdata        = hrdata_ff;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign prog_rdata    = prog_rdata_ff;
  assign sleeping      = sleeping_ff;
  assign erase_data    = erase_data_ff;
  assign erase_program = erase_prog_ff;

  a_cfg_readback: assert property (@(posedge hclk) // [R3]
    disable iff (!hresetn)
    prog_mode && prog_addr == CFG_ADDR |=> prog_rdata[15:13] == CFG_UNIMPL
    && prog_rdata[12:0] == $past(nvm_ff))
    else $error("config readback wrong");

  a_nonprog_write: assert property (@(posedge hclk) // [R1]
    disable iff (!hresetn)
    !prog_mode |=> nvm_ff == $past(nvm_ff))
    else $error("config word changed outside programming");

  a_data_erase: assert property (@(posedge hclk) // [R15]
    disable iff (!hresetn)
    cfg_wr && !nvm_ff.data_protect_n && prog_wdata[7] |=> erase_data)
    else $error("data erase missing");

  a_prog_erase: assert property (@(posedge hclk) // [R16]
    disable iff (!hresetn)
    erase_program |-> $past(cfg_wr) && !$past(nvm_ff.program_protect_n))
    else $error("spurious program erase");

  a_erase_once: assert property (@(posedge hclk) // [R15]
    disable iff (!hresetn)
    erase_data || erase_program |=> !erase_data && !erase_program)
    else $error("erase pulse longer than one cycle");

  a_cfg_stable: assert property (@(posedge hclk) // [R24]
    disable iff (!hresetn)
    state_ff == ST_RUN && $past(state_ff) == ST_RUN
    |-> $stable(cfg_ff))
    else $error("options changed while running");

  a_powerup_delay_timer_length: assert property (@(posedge hclk) // [R18]
    disable iff (!hresetn)
    state_ff == ST_POWERUP_DELAY_TIMER && nxt_state != ST_POWERUP_DELAY_TIMER && !bor_active
    |-> cnt_ff == TCNT_W'(POWERUP_DELAY_TIMER_TICKS - 1) && lf_osc_tick)
    else $error("power-up delay ended early");

  a_powerup_delay_timer_skip: assert property (@(posedge hclk) // [R14]
    disable iff (!hresetn)
    state_ff == ST_LOAD && !bor_active && nvm_ff.powerup_delay_enable_n
    |=> state_ff != ST_POWERUP_DELAY_TIMER)
    else $error("power-up delay ran while disabled");

  a_ost_length: assert property (@(posedge hclk) // [R19]
    disable iff (!hresetn)
    state_ff == ST_OST && nxt_state == ST_RUN
    |-> cnt_ff == TCNT_W'(OST_CYCLES - 1) && osc_clk_tick)
    else $error("start-up timer ended early");

  // A cut brown-out may end in one cycle when no timer is selected
  a_bor_hold: assert property (@(posedge hclk) // [R20]
    disable iff (!hresetn)
    bor_active |=> state_ff == ST_LOAD && device_reset)
    else $error("brown-out did not hold reset");

  a_osc_off: assert property (@(posedge hclk) // [R17]
    disable iff (!hresetn)
    cfg_ff.reset_pin_select && !external_reset_n && is_rc_int
    |-> int_osc_disable)
    else $error("internal oscillator not stopped");

  a_ext_hold: assert property (@(posedge hclk) // [R10]
    disable iff (!hresetn)
    cfg_ff.reset_pin_select && !external_reset_n |-> device_reset)
    else $error("reset pin did not hold reset");

  a_pin_ignored: assert property (@(posedge hclk) // [R10]
    disable iff (!hresetn)
    !cfg_ff.reset_pin_select && state_ff == ST_RUN |-> !device_reset)
    else $error("input pin caused a reset");

  a_sleep_wake: assert property (@(posedge hclk) // [R21]
    disable iff (!hresetn)
    sleeping_ff && (wdt_wakeup || irq_pending) |=> !sleeping_ff)
    else $error("no wake from sleep");

  a_bor_sleep: assert property (@(posedge hclk) // [R7]
    disable iff (!hresetn)
    cfg_ff.brownout_select == BOR_RUN_ONLY && sleeping_ff
    |-> !brownout_enable)
    else $error("brown-out left on in sleep");

  a_bor_soft: assert property (@(posedge hclk) // [R22]
    disable iff (!hresetn)
    cfg_ff.brownout_select == BOR_SOFT |-> brownout_enable == soft_bor_ff)
    else $error("soft brown-out enable ignored");

endmodule

// File: testbench/cws_prog_model.sv
// Purpose: Programmer model for the configuration word port
// Assumes: Lines change just after a rising edge of hclk
// Notes:   Idle address and data carry the inverse of their last value; mode and write go low
`timescale 1ns/1ps
module cws_prog_model (
  input  wire logic        hclk,
  input  wire logic [15:0] prog_rdata,
  output logic             prog_mode,
  output logic             prog_wr,
  output logic [13:0]      prog_addr,
  output logic [13:0]      prog_wdata
);
  import cws_pkg::*;

  initial begin
    prog_mode = 1'b0;
    prog_wr = 1'b0;
    prog_addr = 14'h0000;
    prog_wdata = 14'h0000;
  end

  // One write pulse; caller picks mode and address to test refusals
  task automatic put(input logic [13:0] w, input logic m,
                     input logic [13:0] a);
    prog_mode <= m;
    prog_addr <= a;
    prog_wdata <= w;
    prog_wr <= 1'b1;
    @(posedge hclk);
    prog_mode <= 1'b0;
    prog_wr <= 1'b0;
    prog_addr <= ~a;
    prog_wdata <= ~w;
    @(posedge hclk);
  endtask

  // Mode and address held until the registered readback lands
  task automatic get(output logic [15:0] d);
    prog_mode <= 1'b1;
    prog_addr <= CFG_ADDR;
    @(posedge hclk);
    @(posedge hclk);
    d = prog_rdata;
    prog_mode <= 1'b0;
    prog_addr <= ~CFG_ADDR;
    @(posedge hclk);
  endtask
endmodule

// File: testbench/tb_config_word_startup_options.sv
// Purpose: Self-checking bench for the configuration word start-up block
// Assumes: Zero-wait bus slave; tick inputs pulse every cycle when on
// Notes:   Brown-out reloads the word, since hresetn also clears it
`timescale 1ns/1ps
module tb_config_word_startup_options;
  import cws_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        prog_mode, prog_wr, lf_osc_tick, osc_clk_tick;
  logic        brownout_detect, external_reset_n, sleep_req;
  logic        wdt_wakeup, irq_pending, brownout_enable;
  logic        watchdog_enable, reset_pin_input, int_osc_disable;
  logic        device_reset, sleeping, erase_data, erase_program;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [13:0] prog_addr, prog_wdata;
  logic [15:0] prog_rdata, r16;
  logic [31:0] haddr, hwdata, hrdata, q;
  cws_opts_s   options;
  wire         hready = hreadyout;
  int          fails = 0;
  int          total_checks = 0;
  int          n_ed = 0;
  int          n_ep = 0;
  // Protection on, internal osc, reset pin on; then protection off, XT
  localparam logic [13:0] W_A = 14'h3F34;
  localparam logic [13:0] W_B = 14'h23C9;

  cws_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .prog_mode, .prog_wr,
    .prog_addr, .prog_wdata, .prog_rdata, .lf_osc_tick, .osc_clk_tick,
    .brownout_detect, .external_reset_n, .sleep_req, .wdt_wakeup,
    .irq_pending, .options, .brownout_enable, .watchdog_enable,
    .reset_pin_input, .int_osc_disable, .device_reset, .sleeping,
    .erase_data, .erase_program);
  cws_prog_model i_prog (.hclk, .prog_rdata, .prog_mode, .prog_wr,
    .prog_addr, .prog_wdata);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    n_ed <= n_ed + int'(erase_data === 1'b1);
    n_ep <= n_ep + int'(erase_program === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic cws_opts_s eo(input logic [13:0] w);
    eo = '{~w[12], w[12], w[11], w[10], ~w[7], ~w[6], w[5], ~w[4],
           cws_osc_e'(w[2:0])};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  // A brown-out pulse is the only reload that keeps the stored word
  task automatic load(input logic [13:0] w);
    i_prog.put(w, 1'b1, CFG_ADDR);
    brownout_detect <= 1'b1;
    cyc(3);
    brownout_detect <= 1'b0;
    cyc(1);
  endtask

  task automatic wait_run(input int n);
    int k;
    k = 0;
    while (device_reset !== 1'b0 && k < n) begin
      @(posedge hclk);
      k++;
    end
    chk({31'h0, device_reset}, 32'h0);
  endtask

  task automatic close_out();
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic nap();
    sleep_req <= 1'b1;
    cyc(1);
    sleep_req <= 1'b0;
    cyc(1);
  endtask

  initial begin
    #500000;
    fails++;
    close_out();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lf_osc_tick = 1'b0;
    osc_clk_tick = 1'b0;
    brownout_detect = 1'b0;
    external_reset_n = 1'b1;
    sleep_req = 1'b0;
    wdt_wakeup = 1'b0;
    irq_pending = 1'b0;
    cyc(10);
    hresetn <= 1'b1;
    cyc(1);
    wait_run(20);
    chk(32'(options), 32'(eo(CFG_ERASED)));
    chk({31'h0, brownout_enable}, 32'h1);
    chk({31'h0, watchdog_enable}, 32'h1);
    ahb(1'b1, REG_CFG, 32'h0);
    rd(REG_CFG, 32'hFFFF, 32'hFFFF);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0);
    i_prog.put(14'h0000, 1'b0, CFG_ADDR);
    i_prog.put(14'h0000, 1'b1, 14'h2006);
    i_prog.get(r16);
    chk({16'h0, r16}, 32'hFFFF);
    i_prog.put(W_A, 1'b1, CFG_ADDR);
    cyc(2);
    chk(n_ed + n_ep, 32'h0);
    load(W_A);
    wait_run(20);
    chk(32'(options), 32'(eo(W_A)));
    rd(REG_CFG, 32'hFFFF, {16'h0, 3'h7, W_A[12:0]});
    chk({31'h0, watchdog_enable}, 32'h0);
    ahb(1'b1, REG_WATCHDOG_CONTROL_REG, 32'h1);
    rd(REG_STATUS, 32'h10, 32'h10);
    external_reset_n <= 1'b0;
    cyc(2);
    chk(32'({reset_pin_input, device_reset, int_osc_disable}), 32'h7);
    external_reset_n <= 1'b1;
    cyc(2);
    for (int i = 0; i < 3; i++) begin
      nap();
      chk({31'h0, sleeping}, 32'h1);
      irq_pending <= (i == 0);
      wdt_wakeup <= (i == 1);
      external_reset_n <= (i != 2);
      cyc(2);
      chk({31'h0, sleeping}, 32'h0);
      irq_pending <= 1'b0;
      wdt_wakeup <= 1'b0;
      external_reset_n <= 1'b1;
      cyc(2);
    end
    i_prog.put(W_B, 1'b1, CFG_ADDR);
    cyc(2);
    chk(n_ed, 32'h1);
    chk(n_ep, 32'h1);
    chk(32'(options), 32'(eo(W_A)));
    i_prog.get(r16);
    chk({16'h0, r16}, {16'h0, 3'h7, W_B[12:0]});
    // Timer ticks held off: hclk alone must not end the power-up delay
    load(W_B);
    cyc(2500);
    chk({31'h0, device_reset}, 32'h1);
    rd(REG_STATUS, 32'h6, 32'h2);
    lf_osc_tick <= 1'b1;
    // Read lands one edge before the last tick of the delay
    cyc(1982);
    rd(REG_STATUS, 32'h6, 32'h2);
    cyc(16);
    rd(REG_STATUS, 32'h6, 32'h4);
    osc_clk_tick <= 1'b1;
    wait_run(1100);
    chk(32'(options), 32'(eo(W_B)));
    external_reset_n <= 1'b0;
    cyc(2);
    chk(32'({reset_pin_input, device_reset, int_osc_disable}), 32'h0);
    external_reset_n <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      load(14'h3FF8 | 14'(c));
      wait_run(1200);
      chk(32'(options), 32'(eo(14'h3FF8 | 14'(c))));
    end
    // RC clock words, so no start-up timer stretches these runs
    load(14'h3DFF);
    wait_run(20);
    chk({31'h0, brownout_enable}, 32'h0);
    ahb(1'b1, REG_POWER_CONTROL_REG, 32'h1);
    rd(REG_STATUS, 32'h8, 32'h8);
    load(14'h3EFF);
    wait_run(20);
    chk({31'h0, brownout_enable}, 32'h1);
    nap();
    chk({31'h0, brownout_enable}, 32'h0);
    irq_pending <= 1'b1;
    cyc(2);
    irq_pending <= 1'b0;
    load(14'h3CFF);
    wait_run(20);
    brownout_detect <= 1'b1;
    cyc(3);
    chk({31'h0, device_reset}, 32'h0);
    brownout_detect <= 1'b0;
    close_out();
  end
endmodule
